// ---- shared/rtf_params.svh ----
// timing, width and layout constants for the relay timer function set
// assumes every interval is counted in ticks of one shared timebase strobe
`ifndef RTF_PARAMS_SVH
`define RTF_PARAMS_SVH
// ****************************************
// widths
// ****************************************
`define RTF_TW            16
`define RTF_NW            4
// ****************************************
// counts and reset values
// ****************************************
`define RTF_N_MIN         4'h1
`define RTF_N_MAX         4'h9
`define RTF_ZERO_T        16'h0000
`define RTF_ONE_T         16'h0001
`define RTF_LFSR_SEED     16'hACE1
`define RTF_LFSR_TAPS     16'hB400
// ****************************************
// field positions inside the ahb control word
// ****************************************
`define RTF_CTL_TRAIN_RET 0
`define RTF_CTL_PGEN_RET  1
`define RTF_CTL_STAIR_RET 2
`define RTF_CTL_WARN_EN   3
`define RTF_CTL_N_LSB     4
// ****************************************
// register byte offsets
// ****************************************
`define RTF_OFS_CTRL      12'h000
`define RTF_OFS_TR_LOW    12'h004
`define RTF_OFS_TR_HIGH   12'h008
`define RTF_OFS_PG_LOW    12'h00C
`define RTF_OFS_PG_HIGH   12'h010
`define RTF_OFS_RN_HIGH   12'h014
`define RTF_OFS_RN_LOW    12'h018
`define RTF_OFS_ST_OFF    12'h01C
`define RTF_OFS_ST_WSTART 12'h020
`define RTF_OFS_ST_WLEN   12'h024
`define RTF_OFS_STATUS    12'h028
`define RTF_OFS_TR_ELAPSE 12'h02C
`define RTF_OFS_ST_ELAPSE 12'h030
`define RTF_CTRL_RST      32'h0000_0010
`endif

// ---- shared/rtf_pkg.sv ----
// types shared by the relay timer function set
// assumes rtf_params.svh is included before this file
`include "rtf_params.svh"
package rtf_pkg;
   typedef logic [`RTF_TW-1:0] rtf_time_t;
   typedef struct packed {
      rtf_time_t low_time;
      rtf_time_t high_time;
   } rtf_lh_s;
   typedef struct packed {
      rtf_time_t off_delay;
      rtf_time_t warn_start;
      rtf_time_t warn_len;
      logic      warn_en;
   } rtf_stair_s;
   typedef enum logic [3:0] {
      RTF_TR_IDLE = 4'b0001,
      RTF_TR_LOW  = 4'b0010,
      RTF_TR_HIGH = 4'b0100,
      RTF_TR_DONE = 4'b1000
   } rtf_tr_e;
   typedef enum logic [3:0] {
      RTF_RN_OFF    = 4'b0001,
      RTF_RN_ON_DLY = 4'b0010,
      RTF_RN_ON     = 4'b0100,
      RTF_RN_OFF_DLY= 4'b1000
   } rtf_rn_e;
endpackage

// ---- rtl/rtf_tick_cnt.sv ----
// tick counter for one interval: clears, counts on strobe, flags expiry
// assumes the clear and tick inputs are synchronous single-cycle levels
`timescale 1ns/10ps
`include "rtf_params.svh"
module rtf_tick_cnt (
   input  wire logic              i_clk,
   input  wire logic              i_rst,
   input  wire logic              i_clr,
   input  wire logic              i_tick,
   input  wire rtf_pkg::rtf_time_t i_limit,
   output logic                   o_hit,
   output rtf_pkg::rtf_time_t     o_count
);
   rtf_pkg::rtf_time_t cnt_q;
   rtf_pkg::rtf_time_t cnt_d;
   // ****************************************
   // counter
   // ****************************************
   always_comb begin
      cnt_d = cnt_q;
      if (i_clr) begin
         cnt_d = `RTF_ZERO_T;
      end else if (i_tick && (cnt_q != i_limit)) begin
         cnt_d = cnt_q + `RTF_ONE_T;
      end
   end
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         cnt_q <= `RTF_ZERO_T;
      end else begin
         cnt_q <= cnt_d;
      end
   end
   // expiry when the elapsed count equals the configured value
   assign o_hit   = (cnt_q == i_limit);
   assign o_count = cnt_q;
endmodule

// ---- rtl/rtf_lfsr.sv ----
// free-running pseudo-random source bounded to a maximum time
// assumes nothing beyond the shared clock and reset
`timescale 1ns/10ps
`include "rtf_params.svh"
module rtf_lfsr (
   input  wire logic              i_clk,
   input  wire logic              i_rst,
   input  wire rtf_pkg::rtf_time_t i_max,
   output rtf_pkg::rtf_time_t     o_sample
);
   rtf_pkg::rtf_time_t lfsr_q;
   rtf_pkg::rtf_time_t lfsr_d;
   logic [2*`RTF_TW-1:0] prod;
   always_comb begin
      lfsr_d = lfsr_q[0] ? ((lfsr_q >> 1) ^ `RTF_LFSR_TAPS) : (lfsr_q >> 1);
   end
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         lfsr_q <= `RTF_LFSR_SEED;
      end else begin
         lfsr_q <= lfsr_d;
      end
   end
   // scale by multiply so the sample stays in 0..max, cheaper than a modulo
   assign prod     = lfsr_q * ({1'b0, i_max} + 17'h0_0001);
   assign o_sample = prod[2*`RTF_TW-1:`RTF_TW];
endmodule

// ---- rtl/rtf_top.sv ----
// relay timer function set: pulse train, pulse generator, random relay, stairwell switch
// assumes inputs come synchronous from other logic blocks, settings over ahb-lite
`timescale 1ns/10ps
`include "rtf_params.svh"
module rtf_top (
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   input  wire logic        i_power_loss,
   input  wire logic        i_tick,
   input  wire logic        i_train_trg,
   input  wire logic        i_train_rst,
   input  wire logic        i_pgen_en,
   input  wire logic        i_pgen_inv,
   input  wire logic        i_rand_en,
   input  wire logic        i_stair_trg,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   output logic             o_train_q,
   output logic             o_pgen_q,
   output logic             o_rand_q,
   output logic             o_stair_q
);
   // ****************************************
   // ahb-lite register slave
   // ****************************************
   logic [31:0]         ctrl_q, ctrl_d;
   rtf_pkg::rtf_lh_s    tr_cfg_q, tr_cfg_d, pg_cfg_q, pg_cfg_d, rn_cfg_q, rn_cfg_d;
   rtf_pkg::rtf_stair_s st_cfg_q, st_cfg_d;
   logic                wr_pend_q, wr_pend_d;
   logic [11:0]         wr_addr_q, wr_addr_d;
   logic [31:0]         rdata_q, rdata_d;
   logic                acc;
   logic [`RTF_NW-1:0]  n_cfg;
   rtf_pkg::rtf_time_t  tr_elapsed, st_elapsed;
   assign acc       = hsel && hready && htrans[1];
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = rdata_q;
   // counts outside 1..9 are clamped so a cycle count is always valid
   assign n_cfg = (ctrl_q[`RTF_CTL_N_LSB+:`RTF_NW] < `RTF_N_MIN) ? `RTF_N_MIN :
                  (ctrl_q[`RTF_CTL_N_LSB+:`RTF_NW] > `RTF_N_MAX) ? `RTF_N_MAX :
                  ctrl_q[`RTF_CTL_N_LSB+:`RTF_NW];
   always_comb begin
      ctrl_d    = ctrl_q;
      tr_cfg_d  = tr_cfg_q;
      pg_cfg_d  = pg_cfg_q;
      rn_cfg_d  = rn_cfg_q;
      st_cfg_d  = st_cfg_q;
      wr_pend_d = acc && hwrite;
      wr_addr_d = acc ? haddr[11:0] : wr_addr_q;
      rdata_d   = rdata_q;
      if (wr_pend_q) begin
         case (wr_addr_q)
            `RTF_OFS_CTRL:      ctrl_d              = hwdata;
            `RTF_OFS_TR_LOW:    tr_cfg_d.low_time   = hwdata[`RTF_TW-1:0];
            `RTF_OFS_TR_HIGH:   tr_cfg_d.high_time  = hwdata[`RTF_TW-1:0];
            `RTF_OFS_PG_LOW:    pg_cfg_d.low_time   = hwdata[`RTF_TW-1:0];
            `RTF_OFS_PG_HIGH:   pg_cfg_d.high_time  = hwdata[`RTF_TW-1:0];
            `RTF_OFS_RN_HIGH:   rn_cfg_d.high_time  = hwdata[`RTF_TW-1:0];
            `RTF_OFS_RN_LOW:    rn_cfg_d.low_time   = hwdata[`RTF_TW-1:0];
            `RTF_OFS_ST_OFF:    st_cfg_d.off_delay  = hwdata[`RTF_TW-1:0];
            `RTF_OFS_ST_WSTART: st_cfg_d.warn_start = hwdata[`RTF_TW-1:0];
            `RTF_OFS_ST_WLEN:   st_cfg_d.warn_len   = hwdata[`RTF_TW-1:0];
            default:            ctrl_d              = ctrl_q;
         endcase
      end
      st_cfg_d.warn_en = ctrl_d[`RTF_CTL_WARN_EN];
      if (acc && !hwrite) begin
         case (haddr[11:0])
            `RTF_OFS_CTRL:      rdata_d = ctrl_q;
            `RTF_OFS_TR_LOW:    rdata_d = {16'h0000, tr_cfg_q.low_time};
            `RTF_OFS_TR_HIGH:   rdata_d = {16'h0000, tr_cfg_q.high_time};
            `RTF_OFS_PG_LOW:    rdata_d = {16'h0000, pg_cfg_q.low_time};
            `RTF_OFS_PG_HIGH:   rdata_d = {16'h0000, pg_cfg_q.high_time};
            `RTF_OFS_RN_HIGH:   rdata_d = {16'h0000, rn_cfg_q.high_time};
            `RTF_OFS_RN_LOW:    rdata_d = {16'h0000, rn_cfg_q.low_time};
            `RTF_OFS_ST_OFF:    rdata_d = {16'h0000, st_cfg_q.off_delay};
            `RTF_OFS_ST_WSTART: rdata_d = {16'h0000, st_cfg_q.warn_start};
            `RTF_OFS_ST_WLEN:   rdata_d = {16'h0000, st_cfg_q.warn_len};
            `RTF_OFS_STATUS:    rdata_d = {28'h000_0000, o_stair_q, o_rand_q, o_pgen_q, o_train_q};
            `RTF_OFS_TR_ELAPSE: rdata_d = {16'h0000, tr_elapsed};
            `RTF_OFS_ST_ELAPSE: rdata_d = {16'h0000, st_elapsed};
            default:            rdata_d = 32'h0000_0000;
         endcase
      end
   end
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         ctrl_q    <= `RTF_CTRL_RST;
         tr_cfg_q  <= '0;
         pg_cfg_q  <= '0;
         rn_cfg_q  <= '0;
         st_cfg_q  <= '0;
         wr_pend_q <= 1'b0;
         wr_addr_q <= 12'h000;
         rdata_q   <= 32'h0000_0000;
      end else begin
         ctrl_q    <= ctrl_d;
         tr_cfg_q  <= tr_cfg_d;
         pg_cfg_q  <= pg_cfg_d;
         rn_cfg_q  <= rn_cfg_d;
         st_cfg_q  <= st_cfg_d;
         wr_pend_q <= wr_pend_d;
         wr_addr_q <= wr_addr_d;
         rdata_q   <= rdata_d;
      end
   end
   // ****************************************
   // edge detection of the train trigger, random enable and stair trigger inputs
   // ****************************************
   logic tr_trg_q, rn_en_q, st_trg_q;
   logic tr_rise, rn_rise, rn_fall, st_rise, st_fall;
   assign tr_rise = i_train_trg && !tr_trg_q;
   assign rn_rise = i_rand_en && !rn_en_q;
   assign rn_fall = !i_rand_en && rn_en_q;
   assign st_rise = i_stair_trg && !st_trg_q;
   assign st_fall = !i_stair_trg && st_trg_q;
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         tr_trg_q <= 1'b0;
         rn_en_q  <= 1'b0;
         st_trg_q <= 1'b0;
      end else begin
         tr_trg_q <= i_train_trg;
         rn_en_q  <= i_rand_en;
         st_trg_q <= i_stair_trg;
      end
   end
   // ****************************************
   // pulse train relay
   // ****************************************
   rtf_pkg::rtf_tr_e    tr_st_q, tr_st_d;
   logic [`RTF_NW-1:0]  tr_n_q, tr_n_d;
   logic                tr_clr, tr_hit, tr_wipe;
   // power loss without retention clears state; retained state simply holds
   assign tr_wipe = i_train_rst || (i_power_loss && !ctrl_q[`RTF_CTL_TRAIN_RET]);
   always_comb begin
      tr_st_d = tr_st_q;
      tr_n_d  = tr_n_q;
      tr_clr  = 1'b0;
      if (tr_wipe) begin
         tr_st_d = rtf_pkg::RTF_TR_IDLE;
         tr_clr  = 1'b1;
      end else if (i_power_loss) begin
         tr_st_d = tr_st_q;
      end else if (tr_rise) begin
         tr_st_d = rtf_pkg::RTF_TR_LOW;
         tr_n_d  = `RTF_N_MIN;
         tr_clr  = 1'b1;
      end else begin
         case (tr_st_q)
            rtf_pkg::RTF_TR_LOW: begin
               if (tr_hit) begin
                  tr_st_d = rtf_pkg::RTF_TR_HIGH;
                  tr_clr  = 1'b1;
               end
            end
            rtf_pkg::RTF_TR_HIGH: begin
               if (tr_hit) begin
                  tr_clr = 1'b1;
                  if (tr_n_q >= n_cfg) begin
                     tr_st_d = rtf_pkg::RTF_TR_DONE;
                  end else begin
                     tr_st_d = rtf_pkg::RTF_TR_LOW;
                     tr_n_d  = tr_n_q + 4'h1;
                  end
               end
            end
            rtf_pkg::RTF_TR_IDLE: tr_st_d = tr_st_q;
            rtf_pkg::RTF_TR_DONE: tr_st_d = tr_st_q;
            default:              tr_st_d = rtf_pkg::RTF_TR_IDLE;
         endcase
      end
   end
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         tr_st_q <= rtf_pkg::RTF_TR_IDLE;
         tr_n_q  <= `RTF_N_MIN;
      end else begin
         tr_st_q <= tr_st_d;
         tr_n_q  <= tr_n_d;
      end
   end
   rtf_tick_cnt u_tr_cnt (
      .i_clk   (i_clk),
      .i_rst   (i_rst),
      .i_clr   (tr_clr),
      .i_tick  (i_tick && !i_power_loss),
      .i_limit ((tr_st_q == rtf_pkg::RTF_TR_HIGH) ? tr_cfg_q.high_time : tr_cfg_q.low_time),
      .o_hit   (tr_hit),
      .o_count (tr_elapsed)
   );
   // ****************************************
   // pulse generator
   // ****************************************
   logic pg_ph_q, pg_ph_d, pg_clr, pg_hit, pg_q_d;
   always_comb begin
      pg_ph_d = pg_ph_q;
      pg_clr  = 1'b0;
      if ((i_power_loss && !ctrl_q[`RTF_CTL_PGEN_RET]) || !i_pgen_en) begin
         pg_ph_d = 1'b1;
         pg_clr  = 1'b1;
      end else if (pg_hit && !i_power_loss) begin
         pg_ph_d = !pg_ph_q;
         pg_clr  = 1'b1;
      end
      pg_q_d = i_pgen_en && (pg_ph_d ^ i_pgen_inv);
   end
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         pg_ph_q <= 1'b1;
      end else begin
         pg_ph_q <= pg_ph_d;
      end
   end
   rtf_tick_cnt u_pg_cnt (
      .i_clk   (i_clk),
      .i_rst   (i_rst),
      .i_clr   (pg_clr),
      .i_tick  (i_tick && !i_power_loss),
      .i_limit (pg_ph_q ? pg_cfg_q.high_time : pg_cfg_q.low_time),
      .o_hit   (pg_hit),
      .o_count ()
   );
   // ****************************************
   // random on/off-delay relay
   // ****************************************
   rtf_pkg::rtf_rn_e   rn_st_q, rn_st_d;
   rtf_pkg::rtf_time_t rn_lim_q, rn_lim_d, rn_smp_on, rn_smp_off;
   logic               rn_clr, rn_hit;
   always_comb begin
      rn_st_d  = rn_st_q;
      rn_lim_d = rn_lim_q;
      rn_clr   = 1'b0;
      if (i_power_loss) begin
         rn_st_d = rtf_pkg::RTF_RN_OFF;
         rn_clr  = 1'b1;
      end else begin
         case (rn_st_q)
            rtf_pkg::RTF_RN_OFF, rtf_pkg::RTF_RN_OFF_DLY: begin
               if (rn_rise) begin
                  rn_st_d  = rtf_pkg::RTF_RN_ON_DLY;
                  rn_lim_d = rn_smp_on;
                  rn_clr   = 1'b1;
                  if (rn_st_q == rtf_pkg::RTF_RN_OFF_DLY) begin
                     rn_st_d = rtf_pkg::RTF_RN_ON;
                  end
               end else if ((rn_st_q == rtf_pkg::RTF_RN_OFF_DLY) && rn_hit) begin
                  rn_st_d = rtf_pkg::RTF_RN_OFF;
               end
            end
            rtf_pkg::RTF_RN_ON, rtf_pkg::RTF_RN_ON_DLY: begin
               if (rn_fall) begin
                  rn_st_d  = rtf_pkg::RTF_RN_OFF_DLY;
                  rn_lim_d = rn_smp_off;
                  rn_clr   = 1'b1;
                  if (rn_st_q == rtf_pkg::RTF_RN_ON_DLY) begin
                     rn_st_d = rtf_pkg::RTF_RN_OFF;
                  end
               end else if ((rn_st_q == rtf_pkg::RTF_RN_ON_DLY) && rn_hit) begin
                  rn_st_d = rtf_pkg::RTF_RN_ON;
               end
            end
            default: rn_st_d = rtf_pkg::RTF_RN_OFF;
         endcase
      end
   end
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         rn_st_q  <= rtf_pkg::RTF_RN_OFF;
         rn_lim_q <= `RTF_ZERO_T;
      end else begin
         rn_st_q  <= rn_st_d;
         rn_lim_q <= rn_lim_d;
      end
   end
   rtf_lfsr u_rn_on (
      .i_clk    (i_clk),
      .i_rst    (i_rst),
      .i_max    (rn_cfg_q.high_time),
      .o_sample (rn_smp_on)
   );
   rtf_lfsr u_rn_off (
      .i_clk    (i_clk),
      .i_rst    (i_rst),
      .i_max    (rn_cfg_q.low_time),
      .o_sample (rn_smp_off)
   );
   rtf_tick_cnt u_rn_cnt (
      .i_clk   (i_clk),
      .i_rst   (i_rst),
      .i_clr   (rn_clr),
      .i_tick  (i_tick),
      .i_limit (rn_lim_q),
      .o_hit   (rn_hit),
      .o_count ()
   );
   // ****************************************
   // stairwell switch
   // ****************************************
   logic st_on_q, st_on_d, st_clr, st_hit, st_warn;
   always_comb begin
      st_on_d = st_on_q;
      st_clr  = 1'b0;
      if (i_power_loss && !ctrl_q[`RTF_CTL_STAIR_RET]) begin
         st_on_d = 1'b0;
         st_clr  = 1'b1;
      end else if (i_power_loss) begin
         st_on_d = st_on_q;
      end else if (st_rise || st_fall) begin
         st_on_d = 1'b1;
         st_clr  = 1'b1;
      end else if (st_on_q && st_hit && !i_stair_trg) begin
         st_on_d = 1'b0;
      end
   end
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         st_on_q <= 1'b0;
      end else begin
         st_on_q <= st_on_d;
      end
   end
   rtf_tick_cnt u_st_cnt (
      .i_clk   (i_clk),
      .i_rst   (i_rst),
      .i_clr   (st_clr),
      .i_tick  (i_tick && !i_stair_trg && !i_power_loss),
      .i_limit (st_cfg_q.off_delay),
      .o_hit   (st_hit),
      .o_count (st_elapsed)
   );
   // warning window counted in the same ticks as the off-delay
   assign st_warn = st_cfg_q.warn_en && !i_stair_trg &&
                    (st_elapsed + st_cfg_q.warn_start >= st_cfg_q.off_delay) &&
                    (st_elapsed + st_cfg_q.warn_start < st_cfg_q.off_delay + st_cfg_q.warn_len);
   // ****************************************
   // registered outputs
   // ****************************************
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_train_q <= 1'b0;
         o_pgen_q  <= 1'b0;
         o_rand_q  <= 1'b0;
         o_stair_q <= 1'b0;
      end else begin
         o_train_q <= (tr_st_d == rtf_pkg::RTF_TR_HIGH);
         o_pgen_q  <= pg_q_d;
         o_rand_q  <= (rn_st_d == rtf_pkg::RTF_RN_ON) || (rn_st_d == rtf_pkg::RTF_RN_OFF_DLY);
         o_stair_q <= st_on_d && !st_warn;
      end
   end
endmodule

// ---- test/rtf_tick_model.sv ----
// far-side model: the shared timebase strobe that the other relay blocks hand in
// assumes one clock and an active-high asynchronous reset
`timescale 1ns/10ps
// ****************************************
// tick source
// ****************************************
module rtf_tick_model #(parameter int DIV = 4) (
   input  wire logic i_clk,
   input  wire logic i_rst,
   output logic      o_tick
);
   logic [7:0] cnt_q;
   // one strobe every DIV cycles feeds every timer, so all times share one base
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         cnt_q  <= 8'h00;
         o_tick <= 1'b0;
      end else begin
         cnt_q  <= (cnt_q == 8'(DIV - 1)) ? 8'h00 : cnt_q + 8'h01;
         o_tick <= (cnt_q == 8'(DIV - 1));
      end
   end
endmodule

// ---- test/rtf_top_assertions.sv ----
// checker on the relay timer outputs and the bus answer
// assumes it is bound onto rtf_top, one clock domain
`timescale 1ns/10ps
// ****************************************
// checker
// ****************************************
module rtf_chk (
   input  wire logic i_clk,
   input  wire logic i_rst,
   input  wire logic i_power_loss,
   input  wire logic i_train_trg,
   input  wire logic i_train_rst,
   input  wire logic i_pgen_en,
   input  wire logic i_rand_en,
   input  wire logic i_stair_trg,
   input  wire logic hreadyout,
   input  wire logic hresp,
   input  wire logic o_train_q,
   input  wire logic o_pgen_q,
   input  wire logic o_rand_q,
   input  wire logic o_stair_q
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   sequence s_stair_rise;
      $rose(i_stair_trg) ##0 !i_power_loss;
   endsequence
   sequence s_stair_fall;
      $fell(i_stair_trg) ##0 !i_power_loss;
   endsequence
   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus answer not ready and okay");
   a_train_start: assert property ($rose(i_train_trg) && !i_train_rst && !i_power_loss |=> !o_train_q)
      else $error("train output not low after trigger");
   a_train_reset: assert property (i_train_rst |=> !o_train_q)
      else $error("train output high after reset input");
   a_pgen_off: assert property (!i_pgen_en && !i_power_loss |=> !o_pgen_q)
      else $error("generator output high while disabled");
   a_rand_set: assert property ($rose(o_rand_q) |-> $past(i_rand_en))
      else $error("random output set while enable low");
   a_rand_clear: assert property ($fell(o_rand_q) && !$past(i_power_loss) |-> !$past(i_rand_en))
      else $error("random output cleared while enable high");
   a_stair_set: assert property (s_stair_rise |=> o_stair_q)
      else $error("stair output not set on trigger");
   a_stair_hold: assert property (s_stair_fall |=> o_stair_q [*2])
      else $error("stair output dropped at trigger release");
endmodule
bind rtf_top rtf_chk u_chk (.i_clk, .i_rst, .i_power_loss, .i_train_trg, .i_train_rst, .i_pgen_en,
   .i_rand_en, .i_stair_trg, .hreadyout, .hresp, .o_train_q, .o_pgen_q, .o_rand_q, .o_stair_q);

// ---- test/testbench.sv ----
// self-checking bench: ahb-lite register access and timer scenarios
// assumes the tick model as timebase and zero-wait bus answers awaited on hreadyout
`timescale 1ns/10ps
// ****************************************
// bench
// ****************************************
module testbench;
   logic        i_clk, i_rst, i_power_loss, i_tick, i_train_trg, i_train_rst;
   logic        i_pgen_en, i_pgen_inv, i_rand_en, i_stair_trg, hsel, hwrite;
   logic [31:0] haddr, hwdata, hrdata, r;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic        hreadyout, hresp, o_train_q, o_pgen_q, o_rand_q, o_stair_q;
   logic [3:0]  pq;
   int          err_total, compares, tr_rise, tr_hi, pg_hi, st_fall;
   rtf_tick_model #(.DIV(4)) u_tick (.i_clk, .i_rst, .o_tick(i_tick));
   rtf_top dut (.i_clk, .i_rst, .i_power_loss, .i_tick, .i_train_trg, .i_train_rst, .i_pgen_en,
      .i_pgen_inv, .i_rand_en, .i_stair_trg, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hrdata, .hreadyout, .hresp, .o_train_q, .o_pgen_q, .o_rand_q, .o_stair_q);
   always #20 i_clk = ~i_clk;
   // edge and tick counters; ticks are sampled where the timers sample them
   always @(posedge i_clk) begin
      pq <= {o_stair_q, 2'b00, o_train_q};
      if (o_train_q === 1'b1 && pq[0] === 1'b0) tr_rise++;
      if (o_train_q === 1'b1 && i_tick === 1'b1) tr_hi++;
      if (o_pgen_q === 1'b1 && i_tick === 1'b1) pg_hi++;
      if (o_stair_q === 1'b0 && pq[3] === 1'b1) st_fall++;
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge i_clk);
   endtask
   task automatic clr();
      tr_rise = 0;
      tr_hi   = 0;
      pg_hi   = 0;
      st_fall = 0;
   endtask
   // one single word transfer; every wait ends on hreadyout sampled high
   task automatic bus(input logic w, input logic [31:0] a, d, output logic [31:0] q);
      @(posedge i_clk);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      haddr  <= a;
      hwrite <= w;
      do @(posedge i_clk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge i_clk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   task automatic trig(input bit stair, input int n);
      if (stair) i_stair_trg <= 1'b1;
      else i_train_trg <= 1'b1;
      cyc(n);
      i_stair_trg <= 1'b0;
      i_train_trg <= 1'b0;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, g);
      compares++;
      if (g !== e) begin
         err_total++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic final_report();
      $display("compares %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // a hang is cut far beyond the roughly one thousand cycles the tests need
   initial begin
      cyc(20000);
      err_total++;
      final_report();
   end
   initial begin
      {i_clk, i_power_loss, i_train_trg, i_train_rst, i_pgen_en, i_pgen_inv} = 6'h00;
      {i_rand_en, i_stair_trg, hsel, hwrite, htrans, haddr, hwdata} = '0;
      hsize = 3'h2;
      i_rst = 1'b1;
      clr();
      cyc(8);
      i_rst <= 1'b0;
      bus(0, 32'h0000_0000, 0, r);
      chk("ctrl reset", 32'h0000_0010, r);
      bus(1, 32'h0000_0004, 32'h0000_0002, r);
      bus(1, 32'h0000_0008, 32'h0000_0003, r);
      bus(0, 32'h0000_0004, 0, r);
      chk("train low time", 32'h0000_0002, r);
      bus(0, 32'h0000_0040, 0, r);
      chk("unmapped read", 32'h0000_0000, r);
      $display("test registers done");
      bus(1, 32'h0000_0000, 32'h0000_0030, r);
      clr();
      trig(0, 1);
      cyc(100);
      chk("train pulses", 3, tr_rise);
      chk("train high ticks", 9, tr_hi);
      chk("train idle", 0, o_train_q);
      // retrigger lands inside the first high phase
      clr();
      trig(0, 1);
      cyc(14);
      trig(0, 1);
      cyc(100);
      chk("retrigger pulses", 4, tr_rise);
      clr();
      trig(0, 1);
      cyc(14);
      i_train_rst <= 1'b1;
      cyc(1);
      i_train_rst <= 1'b0;
      cyc(80);
      chk("reset pulses", 1, tr_rise);
      clr();
      trig(0, 1);
      cyc(14);
      i_power_loss <= 1'b1;
      cyc(2);
      i_power_loss <= 1'b0;
      cyc(80);
      chk("power loss pulses", 1, tr_rise);
      // retained state freezes through the loss, so all three pulses still come
      bus(1, 32'h0000_0000, 32'h0000_0031, r);
      clr();
      trig(0, 1);
      cyc(14);
      i_power_loss <= 1'b1;
      cyc(2);
      i_power_loss <= 1'b0;
      cyc(80);
      chk("retained pulses", 3, tr_rise);
      $display("test pulse train done");
      // 24 ticks of a 2 high, 1 low wave; phase at the window edges gives one tick of slack
      bus(1, 32'h0000_0010, 32'h0000_0002, r);
      bus(1, 32'h0000_000C, 32'h0000_0001, r);
      clr();
      i_pgen_en <= 1'b1;
      cyc(96);
      i_pgen_en <= 1'b0;
      cyc(2);
      chk("pgen high ticks", 1, pg_hi >= 15 && pg_hi <= 17);
      chk("pgen stopped", 0, o_pgen_q);
      clr();
      i_pgen_inv <= 1'b1;
      i_pgen_en  <= 1'b1;
      cyc(96);
      i_pgen_en <= 1'b0;
      cyc(2);
      chk("pgen inverted ticks", 1, pg_hi >= 7 && pg_hi <= 9);
      $display("test generator done");
      bus(1, 32'h0000_0014, 32'h0000_0005, r);
      bus(1, 32'h0000_0018, 32'h0000_0005, r);
      i_rand_en <= 1'b1;
      cyc(40);
      chk("random on", 1, o_rand_q);
      bus(0, 32'h0000_0028, 0, r);
      chk("status word", 32'h0000_0004, r);
      i_rand_en <= 1'b0;
      cyc(40);
      chk("random off", 0, o_rand_q);
      // enable stays high through the loss, so no new rise can set it again
      i_rand_en <= 1'b1;
      cyc(40);
      chk("random on again", 1, o_rand_q);
      i_power_loss <= 1'b1;
      cyc(2);
      i_power_loss <= 1'b0;
      cyc(40);
      chk("random power loss", 0, o_rand_q);
      i_rand_en <= 1'b0;
      $display("test random done");
      bus(1, 32'h0000_0000, 32'h0000_0038, r);
      bus(1, 32'h0000_001C, 32'h0000_000A, r);
      bus(1, 32'h0000_0020, 32'h0000_0004, r);
      bus(1, 32'h0000_0024, 32'h0000_0002, r);
      clr();
      trig(1, 2);
      cyc(80);
      chk("stair falls", 2, st_fall);
      chk("stair off", 0, o_stair_q);
      trig(1, 2);
      cyc(20);
      trig(1, 2);
      cyc(20);
      chk("stair restarted", 1, o_stair_q);
      $display("test stairwell done");
      final_report();
   end
endmodule
